// file: rtl/vpc_pkg.sv
// Purpose: Shared constants and types for the VLAN port classifier.
// Assumes: One switch clock, APB register access, 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package vpc_pkg;

   // Register byte offsets
   localparam logic [11:0] OFS_PORT_CFG   = 12'h000;
   localparam logic [11:0] OFS_CUST_TPID  = 12'h004;
   localparam logic [11:0] OFS_MEMB_ADDR  = 12'h008;
   localparam logic [11:0] OFS_MEMB_DATA  = 12'h00C;
   localparam logic [11:0] OFS_STATUS     = 12'h010;
   localparam logic [11:0] OFS_DROP_CNT   = 12'h014;
   localparam logic [11:0] OFS_DYN_REG    = 12'h018;

   // Port configuration field positions
   localparam int PCFG_PORT_DEFAULT_VLAN_ID_LSB  = 0;
   localparam int PCFG_EGRESS_UNTAG_VLAN_ID_LSB  = 12;
   localparam int PCFG_MODE_LSB  = 24;
   localparam int PCFG_TYPE_LSB  = 26;
   localparam int PCFG_FILT_BIT  = 28;
   localparam int PCFG_ACC_LSB   = 29;
   localparam int PCFG_ETAG_LSB  = 30;

   // Membership data bits
   localparam int MEMB_PERM_BIT  = 0;
   localparam int MEMB_BAR_BIT   = 1;

   // Tag protocol identifiers and VLAN IDs
   localparam logic [15:0] TPID_CTAG      = 16'h8100;
   localparam logic [15:0] TPID_STAG      = 16'h88A8;
   localparam logic [15:0] RST_CUST_TPID  = 16'h88A8;
   localparam logic [11:0] RST_PORT_DEFAULT_VLAN_ID       = 12'h001;
   localparam logic [11:0] VID_PRIO       = 12'h000;

   typedef enum logic [1:0] {
      PM_ACCESS = 2'b00,
      PM_TRUNK  = 2'b01,
      PM_HYBRID = 2'b10
   } vpc_mode_t;

   typedef enum logic [1:0] {
      PT_UNAWARE = 2'b00,
      PT_CPORT   = 2'b01,
      PT_SPORT   = 2'b10,
      PT_SCUST   = 2'b11
   } vpc_ptype_t;

   typedef enum logic [1:0] {
      ACC_ALL      = 2'b00,
      ACC_TAGGED   = 2'b01,
      ACC_UNTAGGED = 2'b10
   } vpc_accept_t;

   typedef enum logic [1:0] {
      ET_UNTAG_PORT_DEFAULT_VLAN_ID = 2'b00,
      ET_TAG_ALL    = 2'b01,
      ET_UNTAG_ALL  = 2'b10
   } vpc_etag_t;

   // Received frame header as presented by the port MAC
   typedef struct packed {
      logic        hasTag;
      logic [15:0] tpid;
      logic [11:0] vid;
   } vpc_rx_hdr_t;

   // Ingress decision towards the forwarding engine
   typedef struct packed {
      logic        accept;
      logic        stripTag;
      logic [11:0] classVid;
   } vpc_rx_res_t;

   // Egress request and decision
   typedef struct packed {
      logic        origTag;
      logic [11:0] classVid;
   } vpc_tx_req_t;

   typedef struct packed {
      logic        send;
      logic        addTag;
      logic [15:0] tpid;
   } vpc_tx_res_t;

endpackage : vpc_pkg

// file: rtl/vpc_vlan_port_classifier.sv
// Purpose: Ingress classification and egress tagging for one switch port.
// Assumes: Frame headers arrive from logic on clk; APB slave for setup.
// Notes:   Each decision is registered; answer one cycle after request.
//          Membership is a 4096-entry table of permitted and barred bits.
//
// The register addresses and the APB register port were chosen for this implementation.

// Function
// - Unaware port classifies everything to default VLAN
// - Unaware port keeps any tag on egress
// - Customer port classifies 0x8100 tags by VID
// - Untagged or priority frames use default VLAN
// - VID zero means priority tagged, treated untagged
// - Customer port inserts customer tag
// - Service port classifies 0x8100 or 0x88A8 tags
// - Service port inserts service tag
// - Customer tag 0x8100, service tag 0x88A8
// - Custom port classifies 0x8100 or custom TPID
// - Custom port inserts custom TPID tag
// - Aware port strips recognised tag on ingress
// - Filtering forced on for access and trunk
// - Filtering on drops non-member VLAN frames
// - Filtering off passes non-member VLAN frames
// - Never transmit on non-member VLAN
// - Accept-all setting takes both frame kinds
// - Tagged-only setting discards untagged frames
// - Untagged-only setting discards tagged frames
// - Egress modes: untag default, tag all, untag all
// - Barred VLAN never becomes member
// - Dynamic registration on barred VLAN flags conflict
// - Port stays member of its default VLAN unless it is barred
module vpc_vlan_port_classifier
   import vpc_pkg::*;
#(
   parameter int VID_W = 12
)
(
   input  wire logic        clk,       // Switch clock, 125 MHz
   input  wire logic        rst,       // Asynchronous reset, active high
   input  wire logic        psel,      // APB select
   input  wire logic        penable,   // APB access phase
   input  wire logic        pwrite,    // APB direction
   input  wire logic [11:0] paddr,     // APB byte address
   input  wire logic [31:0] pwdata,    // APB write data
   output logic             pready,    // APB ready
   output logic [31:0]      prdata,    // APB read data
   output logic             pslverr,   // APB error for unmapped address
   input  wire logic        rxValid,   // Ingress header strobe
   input  vpc_rx_hdr_t      rxHdr,     // Ingress header fields
   output logic             rxResValid, // Ingress decision strobe
   output vpc_rx_res_t      rxRes,     // Ingress decision
   input  wire logic        txValid,   // Egress request strobe
   input  vpc_tx_req_t      txReq,     // Egress request fields
   output logic             txResValid, // Egress decision strobe
   output vpc_tx_res_t      txRes,     // Egress decision
   input  wire logic        dynRegValid, // Dynamic VLAN user registration strobe
   input  wire logic [11:0] dynRegVid, // VLAN that the dynamic user registers
   output logic             conflict   // Sticky conflict flag
);

   // Elaboration check: the membership table is sized for 12-bit VIDs only
   if (VID_W != 12)
   begin : g_bad_vid_w
      $error("VID_W must be 12");
   end

   // Register state of the block apart from the membership table
   typedef struct packed {
      logic [11:0] port_default_vlan_id;
      logic [11:0] egress_untag_vlan_id;
      vpc_mode_t   mode;
      vpc_ptype_t  ptype;
      logic        filtCfg;
      vpc_accept_t accept;
      vpc_etag_t   etag;
      logic [15:0] custTpid;
      logic [11:0] membAddr;
      logic        rdy;
      logic [31:0] rdata;
      logic        slvErr;
      logic        rxV;
      vpc_rx_res_t rxR;
      logic        txV;
      vpc_tx_res_t txR;
      logic        confl;
      logic [11:0] conflVid;
      logic [15:0] dropCnt;
   } vpc_state_t;

   vpc_state_t state_ff;
   vpc_state_t nxt_state;

   // Membership table kept apart from the struct; too big for one vector
   logic [4095:0] permit_ff;
   logic [4095:0] barred_ff;

   logic          apbAcc;
   logic          apbWr;
   logic          membWr;
   logic          rxTagged;
   logic          rxKnown;
   logic [11:0]   rxVid;
   logic          filtOn;
   logic          rxMember;

   // A port is a member when not barred and either permitted or on its own default VLAN
   function automatic logic isMember(input logic [11:0] vid,
                                     input logic [11:0] port_default_vlan_id,
                                     input logic        perm,
                                     input logic        bar);
      isMember = !bar && (perm || vid == port_default_vlan_id);
   endfunction : isMember

   assign apbAcc = psel && penable && !state_ff.rdy;
   assign apbWr  = apbAcc && pwrite;
   assign membWr = apbWr && paddr == OFS_MEMB_DATA;

   // Ingress tag recognition by port type
   always_comb
   begin
      rxKnown = 1'b0;
      case (state_ff.ptype)
         PT_CPORT: rxKnown = rxHdr.tpid == TPID_CTAG;
         PT_SPORT: rxKnown = rxHdr.tpid == TPID_CTAG || rxHdr.tpid == TPID_STAG;
         PT_SCUST: rxKnown = rxHdr.tpid == TPID_CTAG
                             || rxHdr.tpid == state_ff.custTpid;
         default:  rxKnown = 1'b0;
      endcase
      // Unknown TPID counts as untagged; VID zero is priority tagged
      rxTagged = rxHdr.hasTag && rxKnown && rxHdr.vid != VID_PRIO;
      rxVid    = rxTagged ? rxHdr.vid : state_ff.port_default_vlan_id;
   end

   // Access and trunk ports filter always; only hybrid may turn it off
   assign filtOn   = state_ff.mode != PM_HYBRID || state_ff.filtCfg;
   assign rxMember = isMember(rxVid, state_ff.port_default_vlan_id, permit_ff[rxVid], barred_ff[rxVid]);

   // Next-state logic: APB, ingress, egress, conflict
   always_comb
   begin
      logic        accOk;
      logic        tagOut;
      logic [11:0] txVid;
      accOk  = 1'b0;
      tagOut = 1'b0;
      txVid  = txReq.classVid;
      nxt_state = state_ff;

      // APB answers in the cycle after the access phase opens
      nxt_state.rdy    = apbAcc;
      nxt_state.slvErr = 1'b0;
      if (apbAcc)
      begin
         nxt_state.rdata = 32'h0000_0000;
         if (paddr == OFS_PORT_CFG)
         begin
            if (pwrite)
            begin
               nxt_state.port_default_vlan_id    = pwdata[PCFG_PORT_DEFAULT_VLAN_ID_LSB +: 12];
               nxt_state.egress_untag_vlan_id    = pwdata[PCFG_EGRESS_UNTAG_VLAN_ID_LSB +: 12];
               nxt_state.mode    = vpc_mode_t'(pwdata[PCFG_MODE_LSB +: 2]);
               nxt_state.ptype   = vpc_ptype_t'(pwdata[PCFG_TYPE_LSB +: 2]);
               nxt_state.filtCfg = pwdata[PCFG_FILT_BIT];
               nxt_state.accept  = vpc_accept_t'({1'b0, pwdata[PCFG_ACC_LSB]});
               nxt_state.etag    = vpc_etag_t'(pwdata[PCFG_ETAG_LSB +: 2]);
            end
            nxt_state.rdata = {state_ff.etag, state_ff.accept[0], state_ff.filtCfg,
                               state_ff.ptype, state_ff.mode, state_ff.egress_untag_vlan_id, state_ff.port_default_vlan_id};
         end
         else if (paddr == OFS_CUST_TPID)
         begin
            if (pwrite)
               nxt_state.custTpid = pwdata[15:0];
            nxt_state.rdata = {16'h0000, state_ff.custTpid};
         end
         else if (paddr == OFS_MEMB_ADDR)
         begin
            if (pwrite)
               nxt_state.membAddr = pwdata[11:0];
            nxt_state.rdata = {20'h00000, state_ff.membAddr};
         end
         else if (paddr == OFS_MEMB_DATA)
         begin
            nxt_state.rdata = {30'h0000_0000, barred_ff[state_ff.membAddr],
                               permit_ff[state_ff.membAddr]};
         end
         else if (paddr == OFS_STATUS)
         begin
            // Write one to bit 0 clears conflict; acceptance high bit here
            if (pwrite && pwdata[0])
               nxt_state.confl = 1'b0;
            if (pwrite)
               nxt_state.accept = vpc_accept_t'({pwdata[1], state_ff.accept[0]});
            nxt_state.rdata = {8'h00, state_ff.conflVid, 10'h000,
                               state_ff.accept[1], state_ff.confl};
         end
         else if (paddr == OFS_DROP_CNT)
         begin
            nxt_state.rdata = {16'h0000, state_ff.dropCnt};
         end
         else
         begin
            nxt_state.slvErr = 1'b1;
         end
      end

      // Ingress decision
      nxt_state.rxV = rxValid;
      if (rxValid)
      begin
         case (state_ff.accept)
            ACC_TAGGED:   accOk = rxTagged;
            ACC_UNTAGGED: accOk = !rxTagged;
            default:      accOk = 1'b1;
         endcase
         nxt_state.rxR.accept   = accOk && (!filtOn || rxMember);
         nxt_state.rxR.stripTag = rxTagged;
         nxt_state.rxR.classVid = rxVid;
         if (!nxt_state.rxR.accept)
            nxt_state.dropCnt = state_ff.dropCnt + 16'h0001;
      end

      // Egress decision
      nxt_state.txV = txValid;
      if (txValid)
      begin
         case (state_ff.etag)
            ET_TAG_ALL:   tagOut = 1'b1;
            ET_UNTAG_ALL: tagOut = 1'b0;
            default:      tagOut = txVid != state_ff.port_default_vlan_id;
         endcase
         nxt_state.txR.send = isMember(txVid, state_ff.port_default_vlan_id, permit_ff[txVid],
                                       barred_ff[txVid]);
         case (state_ff.ptype)
            PT_CPORT: nxt_state.txR.tpid = TPID_CTAG;
            PT_SPORT: nxt_state.txR.tpid = TPID_STAG;
            PT_SCUST: nxt_state.txR.tpid = state_ff.custTpid;
            default:  nxt_state.txR.tpid = TPID_CTAG;
         endcase
         // Unaware ports never add or strip; original tag rides through
         nxt_state.txR.addTag = state_ff.ptype != PT_UNAWARE && tagOut;
      end

      // Set wins over a clear arriving in the same cycle
      if (dynRegValid && barred_ff[dynRegVid])
      begin
         nxt_state.confl    = 1'b1;
         nxt_state.conflVid = dynRegVid;
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff          <= '0;
         state_ff.port_default_vlan_id     <= RST_PORT_DEFAULT_VLAN_ID;
         state_ff.egress_untag_vlan_id     <= RST_PORT_DEFAULT_VLAN_ID;
         state_ff.mode     <= PM_HYBRID;
         state_ff.ptype    <= PT_UNAWARE;
         state_ff.filtCfg  <= 1'b1;
         state_ff.accept   <= ACC_ALL;
         state_ff.etag     <= ET_UNTAG_PORT_DEFAULT_VLAN_ID;
         state_ff.custTpid <= RST_CUST_TPID;
      end
      else
         state_ff <= nxt_state;
   end

   // Membership table; registration cannot override barred bit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         permit_ff    <= {{4095{1'b1}}, 1'b0};
         barred_ff    <= '0;
      end
      else
      begin
         if (membWr)
         begin
            permit_ff[state_ff.membAddr] <= pwdata[MEMB_PERM_BIT];
            barred_ff[state_ff.membAddr] <= pwdata[MEMB_BAR_BIT];
         end
         if (dynRegValid)
            permit_ff[dynRegVid] <= 1'b1;
      end
   end

   assign pready     = state_ff.rdy;
   assign prdata     = state_ff.rdata;
   assign pslverr    = state_ff.rdy && state_ff.slvErr;
   assign rxResValid = state_ff.rxV;
   assign rxRes      = state_ff.rxR;
   assign txResValid = state_ff.txV;
   assign txRes      = state_ff.txR;
   assign conflict   = state_ff.confl;

endmodule : vpc_vlan_port_classifier

// file: test/vpc_sva.sv
// Purpose: Port-level assertions for the VLAN port classifier
// Assumes: Port setup is shadowed from APB writes seen at the ports
// Notes:   A frame racing a setup write is judged like any other; no exclusion
module vpc_sva
   import vpc_pkg::*;
(
   input wire logic        clk,        // Clock
   input wire logic        rst,        // Reset
   input wire logic        psel,       // APB select
   input wire logic        penable,    // APB access
   input wire logic        pwrite,     // APB write
   input wire logic [11:0] paddr,      // APB address
   input wire logic [31:0] pwdata,     // APB data
   input wire logic        pready,     // APB ready
   input wire logic        rxValid,    // Rx strobe
   input vpc_rx_hdr_t      rxHdr,      // Rx header
   input wire logic        rxResValid, // Rx answer
   input vpc_rx_res_t      rxRes,      // Rx decision
   input wire logic        txValid,    // Tx strobe
   input vpc_tx_res_t      txRes       // Tx decision
);
   logic [31:0] cfg_ff;
   logic [15:0] cust_ff, tagTpid;
   logic [11:0] port_default_vlan_id;
   logic [1:0]  ptype;
   logic        useTag;

   // Shadow copy of setup, so expectations follow what software wrote
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_ff  <= 32'h1200_1001;
         cust_ff <= RST_CUST_TPID;
      end
      else if (psel && penable && pready && pwrite)
      begin
         cfg_ff  <= paddr == OFS_PORT_CFG ? pwdata : cfg_ff;
         cust_ff <= paddr == OFS_CUST_TPID ? pwdata[15:0] : cust_ff;
      end
   end

   // A tag counts only on an aware port, with nonzero VID and a TPID the type takes
   assign ptype   = cfg_ff[27:26];
   assign port_default_vlan_id    = cfg_ff[11:0];
   assign tagTpid = ptype == PT_CPORT ? TPID_CTAG : ptype == PT_SPORT ? TPID_STAG : cust_ff;
   assign useTag  = ptype != PT_UNAWARE && rxHdr.hasTag && rxHdr.vid != VID_PRIO
                  && (rxHdr.tpid == TPID_CTAG || (ptype == PT_SPORT && rxHdr.tpid == TPID_STAG)
                  || (ptype == PT_SCUST && rxHdr.tpid == cust_ff));

   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence apbWait;
      psel && penable && !pready;
   endsequence

   AST_APB_ONE_WAIT:
      assert property (apbWait |=> pready ##1 !pready) else $error("APB answer timing");
   AST_RX_ANSWER:
      assert property (rxValid |=> rxResValid) else $error("ingress answer missing");
   AST_UNAWARE_RX:
      assert property (rxValid && ptype == PT_UNAWARE |=> rxRes.classVid == $past(port_default_vlan_id)
         && !rxRes.stripTag) else $error("unaware ingress wrong");
   AST_TAG_VID:
      assert property (rxValid && useTag |=> rxRes.classVid == $past(rxHdr.vid)
         && rxRes.stripTag) else $error("tag VID not used");
   AST_PORT_DEFAULT_VLAN_ID_FALLBACK:
      assert property (rxValid && !useTag |=> rxRes.classVid == $past(port_default_vlan_id))
         else $error("default VLAN not used");
   AST_TX_TPID:
      assert property (txValid |=> !(txRes.send && txRes.addTag)
         || txRes.tpid == $past(tagTpid)) else $error("egress TPID wrong");
   AST_UNAWARE_TX:
      assert property (txValid && ptype == PT_UNAWARE |=> !txRes.addTag)
         else $error("unaware port added tag");
   AST_UNTAG_ALL:
      assert property (txValid && cfg_ff[31:30] == ET_UNTAG_ALL |=> !txRes.addTag)
         else $error("untag-all sent a tag");
   AST_TAGGED_ONLY:
      assert property (rxValid && cfg_ff[29] && !rxHdr.hasTag |=> !rxRes.accept)
         else $error("untagged frame accepted");
endmodule : vpc_sva

bind vpc_vlan_port_classifier vpc_sva chk_u (.clk, .rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .rxValid, .rxHdr, .rxResValid, .rxRes, .txValid, .txRes);

// file: test/vpc_mac_model.sv
// Purpose: Frame-side partner presenting headers as a port MAC would
// Assumes: Callers run one task at a time
// Notes:   Idle header lines are inverted so stale values never look valid
module vpc_mac_model
   import vpc_pkg::*;
(
   input  wire logic   clk,     // Clock
   output logic        rxValid, // Rx strobe
   output vpc_rx_hdr_t rxHdr,   // Rx header
   output logic        txValid, // Tx strobe
   output vpc_tx_req_t txReq    // Tx request
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet at time zero
   initial
   begin
      rxValid = 1'b0;
      txValid = 1'b0;
      rxHdr   = '0;
      txReq   = '0;
   end

   // One-cycle strobe, then scramble
   task automatic sendRx(input vpc_rx_hdr_t h);
      @(posedge clk);
      rxValid <= 1'b1;
      rxHdr   <= h;
      @(posedge clk);
      rxValid <= 1'b0;
      rxHdr   <= ~h;
   endtask : sendRx

   task automatic sendTx(input vpc_tx_req_t q);
      @(posedge clk);
      txValid <= 1'b1;
      txReq   <= q;
      @(posedge clk);
      txValid <= 1'b0;
      txReq   <= ~q;
   endtask : sendTx
endmodule : vpc_mac_model

// file: test/tb.sv
// Purpose: Self-checking bench for the VLAN port classifier
// Assumes: APB answers after one wait state; decisions one cycle on
// Notes:   Setup is written before each frame batch, never alongside one
module tb
   import vpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, errv;
   logic        rxValid, rxResValid, txValid, txResValid, dynRegValid, conflict;
   logic [11:0] paddr, dynRegVid;
   logic [31:0] pwdata, prdata, rdv;
   vpc_rx_hdr_t rxHdr;
   vpc_rx_res_t rxRes;
   vpc_tx_req_t txReq;
   vpc_tx_res_t txRes;
   int          fail_count, compares;

   // Free-running 125 MHz clock
   always #4 clk = ~clk;

   vpc_vlan_port_classifier dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .rxValid, .rxHdr, .rxResValid, .rxRes, .txValid, .txReq,
      .txResValid, .txRes, .dynRegValid, .dynRegVid, .conflict);
   vpc_mac_model mac_u (.clk, .rxValid, .rxHdr, .txValid, .txReq);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Request held until the rising edge that samples pready high; data taken there too
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rdv  = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rx(input logic h, input logic [15:0] t, input logic [11:0] v,
                     input logic acc, input logic strip, input logic [11:0] cv);
      mac_u.sendRx({h, t, v});
      #1;
      chk(32'({rxResValid, rxRes}), 32'({1'b1, acc, strip, cv}));
   endtask : rx

   task automatic tx(input logic o, input logic [11:0] v, input logic snd, input logic add,
                     input logic [15:0] t);
      mac_u.sendTx({o, v});
      #1;
      chk(32'({txResValid, txRes.send}), 32'({1'b1, snd}));
      if (snd)
         chk(32'({txRes.addTag, add && txRes.addTag ? txRes.tpid : t}), 32'({add, t}));
   endtask : tx

   // Port setup word: egress, accept, filter, type, mode, untag VID, default VID
   function automatic logic [31:0] pc(input logic [11:0] pv, input logic [1:0] md,
      input logic [1:0] ty, input logic f, input logic a, input logic [1:0] e);
      return {e, a, f, ty, md, 12'h001, pv};
   endfunction : pc

   task automatic wrap_up();
      if (fail_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   initial
   begin
      #100000;
      fail_count++;
      wrap_up();
   end

   initial
   begin
      {clk, psel, penable, pwrite, dynRegValid, paddr, pwdata, dynRegVid} = '0;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, OFS_PORT_CFG, 32'h0);
      chk(rdv, 32'h1200_1001);
      apb(1'b0, 12'h020, 32'h0);
      chk(32'(errv), 32'h1);
      rx(1'b1, TPID_CTAG, 12'h005, 1'b1, 1'b0, 12'h001);
      tx(1'b1, 12'h005, 1'b1, 1'b0, 16'h0);
      apb(1'b1, OFS_CUST_TPID, 32'h0000_9100);
      // Each aware type against each TPID, untagged and priority frames
      for (int t = 1; t < 4; t++)
      begin
         apb(1'b1, OFS_PORT_CFG, pc(12'h001, PM_HYBRID, 2'(t), 1'b1, 1'b0, ET_UNTAG_PORT_DEFAULT_VLAN_ID));
         rx(1'b1, TPID_CTAG, 12'h00A, 1'b1, 1'b1, 12'h00A);
         rx(1'b1, TPID_STAG, 12'h00B, 1'b1, t == 2, t == 2 ? 12'h00B : 12'h001);
         rx(1'b1, 16'h9100, 12'h00C, 1'b1, t == 3, t == 3 ? 12'h00C : 12'h001);
         rx(1'b0, TPID_CTAG, 12'h00D, 1'b1, 1'b0, 12'h001);
         rx(1'b1, TPID_CTAG, VID_PRIO, 1'b1, 1'b0, 12'h001);
         tx(1'b0, 12'h00A, 1'b1, 1'b1, t == 1 ? TPID_CTAG : t == 2 ? TPID_STAG : 16'h9100);
         tx(1'b1, 12'h001, 1'b1, 1'b0, 16'h0);
      end
      apb(1'b1, OFS_PORT_CFG, pc(12'h001, PM_HYBRID, PT_CPORT, 1'b1, 1'b0, ET_TAG_ALL));
      tx(1'b0, 12'h001, 1'b1, 1'b1, TPID_CTAG);
      apb(1'b1, OFS_PORT_CFG, pc(12'h001, PM_HYBRID, PT_CPORT, 1'b0, 1'b0, ET_UNTAG_ALL));
      tx(1'b1, 12'h00A, 1'b1, 1'b0, 16'h0);
      // VLAN 20 taken out of the permitted set
      apb(1'b1, OFS_MEMB_ADDR, 32'd20);
      apb(1'b1, OFS_MEMB_DATA, 32'h0);
      rx(1'b1, TPID_CTAG, 12'h014, 1'b1, 1'b1, 12'h014);
      tx(1'b1, 12'h014, 1'b0, 1'b0, 16'h0);
      apb(1'b1, OFS_PORT_CFG, pc(12'h001, PM_HYBRID, PT_CPORT, 1'b1, 1'b0, ET_UNTAG_PORT_DEFAULT_VLAN_ID));
      rx(1'b1, TPID_CTAG, 12'h014, 1'b0, 1'b1, 12'h014);
      apb(1'b1, OFS_PORT_CFG, pc(12'h001, PM_ACCESS, PT_CPORT, 1'b0, 1'b0, ET_UNTAG_PORT_DEFAULT_VLAN_ID));
      rx(1'b1, TPID_CTAG, 12'h014, 1'b0, 1'b1, 12'h014);
      apb(1'b1, OFS_PORT_CFG, pc(12'h014, PM_HYBRID, PT_CPORT, 1'b1, 1'b0, ET_UNTAG_PORT_DEFAULT_VLAN_ID));
      rx(1'b0, TPID_CTAG, 12'h000, 1'b1, 1'b0, 12'h014);
      // VLAN 30 barred, then claimed by a dynamic user
      apb(1'b1, OFS_PORT_CFG, pc(12'h001, PM_HYBRID, PT_CPORT, 1'b1, 1'b0, ET_UNTAG_PORT_DEFAULT_VLAN_ID));
      apb(1'b1, OFS_MEMB_ADDR, 32'd30);
      apb(1'b1, OFS_MEMB_DATA, 32'h3);
      @(posedge clk);
      dynRegValid <= 1'b1;
      dynRegVid   <= 12'd30;
      @(posedge clk);
      dynRegValid <= 1'b0;
      #1;
      chk(32'(conflict), 32'h1);
      rx(1'b1, TPID_CTAG, 12'h01E, 1'b0, 1'b1, 12'h01E);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rdv & 32'h00FF_F001, 32'h0001_E001);
      // Acceptance: tagged only, then untagged only
      apb(1'b1, OFS_PORT_CFG, pc(12'h001, PM_HYBRID, PT_CPORT, 1'b0, 1'b1, ET_UNTAG_PORT_DEFAULT_VLAN_ID));
      rx(1'b0, TPID_CTAG, 12'h00A, 1'b0, 1'b0, 12'h001);
      rx(1'b1, TPID_CTAG, 12'h00A, 1'b1, 1'b1, 12'h00A);
      apb(1'b1, OFS_PORT_CFG, pc(12'h001, PM_HYBRID, PT_CPORT, 1'b0, 1'b0, ET_UNTAG_PORT_DEFAULT_VLAN_ID));
      apb(1'b1, OFS_STATUS, 32'h2);
      rx(1'b1, TPID_CTAG, 12'h00A, 1'b0, 1'b1, 12'h00A);
      rx(1'b0, TPID_CTAG, 12'h00A, 1'b1, 1'b0, 12'h001);
      // Five frames were refused above; the drop counter must agree
      apb(1'b0, OFS_DROP_CNT, 32'h0);
      chk(rdv, 32'h0000_0005);
      wrap_up();
   end
endmodule : tb
